// ---- ldsc_host_model.sv ----
// model of the controller that drives the serial chain and reads status back
`timescale 1ns/1ps
module ldsc_host_model (
   input wire logic i_clk,
   input wire logic i_serial_out,
   output logic o_shift_clk,
   output logic o_serial_in,
   output logic o_load_strobe
);
   logic [191:0] cap_r = '0;
   initial begin
      o_shift_clk = 1'b0;
      o_serial_in = 1'b0;
      o_load_strobe = 1'b0;
   end
   // 400 ns shift clock, data set 200 ns before each rise; clock stands low between frames
   task automatic send(input logic [191:0] d, input int n);
      @(posedge i_clk);
      for (int i = n - 1; i >= 0; i--) begin
         o_serial_in <= d[i];
         repeat (4) @(posedge i_clk);
         cap_r <= {cap_r[190:0], i_serial_out};
         o_shift_clk <= 1'b1;
         repeat (4) @(posedge i_clk);
         o_shift_clk <= 1'b0;
      end
      @(posedge i_clk);
      o_serial_in <= ~o_serial_in;
   endtask : send
   task automatic load();
      @(posedge i_clk) o_load_strobe <= 1'b1;
      repeat (4) @(posedge i_clk);
      o_load_strobe <= 1'b0;
      repeat (8) @(posedge i_clk);
   endtask : load
endmodule : ldsc_host_model

// ---- ldsc_pkg.sv ----
// constants of the serial led driver control block
// Operation
// - shift serial input on shift clock rise
// - whole packet first, then load strobe latches
// - packets are sent and read msb first
// - bit leaving register drives serial output
// - mode selects 192 or 96 bit register
// - mode low loads greyscale, high dot correction
// - reset gives greyscale mode, cleared register
// - error line low on thermal or open, on thermal warning instead while disabled with mode high
// - output disable masks open flags from error
// - thermal error flag kept in status data
// - open flag sampled 1us after switch on
// - short flags only in serial status data and apb flags register
// - open flags shifted out in greyscale cycle
// - stagger channels per step, on and off
// - output disable forces all channels off
// - output disable clears greyscale counter
// - enabled channels follow greyscale only, correction is stored
// - greyscale latch loads status packet into register
// - status packet field positions as listed
// - pwm starts on disable fall, compare switches off
// - reset values dot correction 63, greyscale 4095
package ldsc_pkg;
   localparam int NCH = 16;
   localparam int GS_W = 12;
   localparam int DC_W = 6;
   localparam int SR_GS_LEN = 192;
   localparam int SR_DC_LEN = 96;
   localparam int CNT_W = 13;
   localparam logic [CNT_W-1:0] CNT_END = 13'h1000;
   localparam logic [GS_W-1:0] GS_RST = 12'hfff;
   localparam logic [DC_W-1:0] DC_RST = 6'h3f;
   localparam int SID_OPEN_LSB = 176;
   localparam int SID_TEF = 175;
   localparam int SID_TWF = 174;
   localparam int SID_DC_LSB = 72;
   localparam int SID_OPEN2_LSB = 16;
   localparam int SID_SHORT_LSB = 0;
   localparam int CLK_PERIOD_NS = 50;
   localparam int OPEN_SAMPLE_NS = 1000;
   localparam int OPEN_SAMPLE_CYC = (OPEN_SAMPLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int DELAY_STEP_NS = 30;
   localparam int DELAY_STEP_CYC = (DELAY_STEP_NS / CLK_PERIOD_NS < 1) ? 1 :
      DELAY_STEP_NS / CLK_PERIOD_NS;
   localparam int DLY_LEN = NCH * DELAY_STEP_CYC;
   localparam int ADDR_W = 12;
   localparam logic [ADDR_W-1:0] OFS_CTRL = 12'h000;
   localparam logic [ADDR_W-1:0] OFS_STATUS = 12'h004;
   localparam logic [ADDR_W-1:0] OFS_FLAGS = 12'h008;
   localparam logic [ADDR_W-1:0] OFS_COUNT = 12'h00c;
   localparam int CTRL_DETECT_BIT = 0;
   localparam int CTRL_DELAY_BIT = 1;
   localparam logic [1:0] CTRL_RST = 2'h1;
endpackage : ldsc_pkg

// ---- ldsc_top.sv ----
// serial led driver control: shift chain, latches, pwm, error line, apb
`timescale 1ns/1ps
module ldsc_top (
   input wire logic I_CORE_CLK,
   input wire logic I_SRST,
   input wire logic I_SHIFT_CLK,
   input wire logic I_SERIAL_IN,
   input wire logic I_LOAD_STROBE,
   input wire logic I_MODE,
   input wire logic I_OUTPUT_DISABLE,
   input wire logic I_PWM_COUNT_CLOCK,
   input wire logic I_THERMAL_ERROR,
   input wire logic I_THERMAL_WARNING,
   input wire logic [ldsc_pkg::NCH-1:0] I_OPEN_CMP,
   input wire logic [ldsc_pkg::NCH-1:0] I_SHORT_CMP,
   input wire logic I_PSEL,
   input wire logic I_PENABLE,
   input wire logic I_PWRITE,
   input wire logic [ldsc_pkg::ADDR_W-1:0] I_PADDR,
   input wire logic [31:0] I_PWDATA,
   output logic [31:0] O_PRDATA,
   output logic O_PREADY,
   output logic O_PSLVERR,
   output logic O_SERIAL_OUT,
   output logic [ldsc_pkg::NCH-1:0] O_CHANNEL_OUTPUT,
   output logic O_ERROR_LINE_N_O,
   output logic O_ERROR_LINE_N_OE
);
   import ldsc_pkg::*;

   localparam int NPIN = 8 + 2 * NCH;

   function automatic logic [SR_GS_LEN-1:0] ldsc_status(
      input logic [NCH-1:0] open_f,
      input logic [NCH-1:0] short_f,
      input logic thermal_error_flag,
      input logic thermal_warning_flag,
      input logic [NCH*DC_W-1:0] dc_flat
   );
      logic [SR_GS_LEN-1:0] s;
      s = '0;
      s[SID_OPEN_LSB +: NCH] = open_f;
      s[SID_TEF] = thermal_error_flag;
      s[SID_TWF] = thermal_warning_flag;
      s[SID_DC_LSB +: NCH*DC_W] = dc_flat;
      s[SID_OPEN2_LSB +: NCH] = open_f;
      s[SID_SHORT_LSB +: NCH] = short_f;
      return s;
   endfunction : ldsc_status

   // pin synchronisers
   logic [NPIN-1:0] pin_raw;
   logic [NPIN-1:0] pin_meta_r;
   logic [NPIN-1:0] pin_sync_r;
   logic [2:0] edge_prev_r;
   logic sclk_s, sin_s, ld_s, mode_s, od_s, pclk_s, tef_s, twf_s;
   logic [NCH-1:0] open_cmp_s, short_cmp_s;
   logic sclk_rise, ld_rise, pclk_rise;

   assign pin_raw = {I_SHIFT_CLK, I_SERIAL_IN, I_LOAD_STROBE, I_MODE, I_OUTPUT_DISABLE,
      I_PWM_COUNT_CLOCK, I_THERMAL_ERROR, I_THERMAL_WARNING, I_OPEN_CMP, I_SHORT_CMP};

   always_ff @(posedge I_CORE_CLK) begin
      if (I_SRST) begin
         pin_meta_r <= '0;
         pin_sync_r <= '0;
      end else begin
         pin_meta_r <= pin_raw;
         pin_sync_r <= pin_meta_r;
      end
   end

   assign {sclk_s, sin_s, ld_s, mode_s, od_s, pclk_s, tef_s, twf_s, open_cmp_s, short_cmp_s} =
      pin_sync_r;

   always_ff @(posedge I_CORE_CLK) begin
      if (I_SRST) begin
         edge_prev_r <= '0;
      end else begin
         edge_prev_r <= {sclk_s, ld_s, pclk_s};
      end
   end

   assign sclk_rise = sclk_s & ~edge_prev_r[2];
   assign ld_rise = ld_s & ~edge_prev_r[1];
   assign pclk_rise = pclk_s & ~edge_prev_r[0];

   // control register
   logic [1:0] ctrl_r;
   logic detect_en, delay_en;
   assign detect_en = ctrl_r[CTRL_DETECT_BIT];
   assign delay_en = ctrl_r[CTRL_DELAY_BIT];

   // greyscale and dot correction storage
   logic [GS_W-1:0] gs_r [NCH];
   logic [DC_W-1:0] dc_r [NCH];
   logic [NCH*DC_W-1:0] dc_flat;
   logic [NCH-1:0] open_flag_r, short_flag_r;
   logic [SR_GS_LEN-1:0] sr_r;

   always_comb begin
      for (int ch = 0; ch < NCH; ch++) begin
         dc_flat[ch*DC_W +: DC_W] = dc_r[ch];
      end
   end

   // input shift register, msb first, load strobe latch
   always_ff @(posedge I_CORE_CLK) begin
      if (I_SRST) begin
         sr_r <= '0;
      end else if (ld_rise && !mode_s) begin
         sr_r <= ldsc_status(open_flag_r, short_flag_r, tef_s, twf_s, dc_flat);
      end else if (sclk_rise) begin
         sr_r <= {sr_r[SR_GS_LEN-2:0], sin_s};
      end
   end

   always_ff @(posedge I_CORE_CLK) begin
      if (I_SRST) begin
         O_SERIAL_OUT <= 1'b0;
      end else if (mode_s) begin
         O_SERIAL_OUT <= sr_r[SR_DC_LEN-1];
      end else begin
         O_SERIAL_OUT <= sr_r[SR_GS_LEN-1];
      end
   end

   always_ff @(posedge I_CORE_CLK) begin
      if (I_SRST) begin
         for (int ch = 0; ch < NCH; ch++) begin
            gs_r[ch] <= GS_RST;
            dc_r[ch] <= DC_RST;
         end
      end else if (ld_rise) begin
         for (int ch = 0; ch < NCH; ch++) begin
            if (mode_s) begin
               dc_r[ch] <= sr_r[ch*DC_W +: DC_W];
            end else begin
               gs_r[ch] <= sr_r[ch*GS_W +: GS_W];
            end
         end
      end
   end

   // greyscale counter
   logic [CNT_W-1:0] cnt_r;
   logic [NCH-1:0] raw_on_r;

   always_ff @(posedge I_CORE_CLK) begin
      if (I_SRST) begin
         cnt_r <= '0;
      end else if (od_s) begin
         cnt_r <= '0;
      end else if (pclk_rise && cnt_r != CNT_END) begin
         cnt_r <= cnt_r + 13'h0001;
      end
   end

   always_ff @(posedge I_CORE_CLK) begin
      if (I_SRST) begin
         raw_on_r <= '0;
      end else if (od_s) begin
         raw_on_r <= '0;
      end else if (pclk_rise) begin
         for (int ch = 0; ch < NCH; ch++) begin
            if (cnt_r == CNT_END || cnt_r == {1'b0, gs_r[ch]}) begin
               raw_on_r[ch] <= 1'b0;
            end else if (cnt_r == '0) begin
               raw_on_r[ch] <= 1'b1;
            end
         end
      end
   end

   // staggered switching: channel n lags n steps on both edges
   logic [NCH-1:0] dly_r [DLY_LEN];
   logic [NCH-1:0] stag_on;

   always_ff @(posedge I_CORE_CLK) begin
      if (I_SRST) begin
         for (int k = 0; k < DLY_LEN; k++) begin
            dly_r[k] <= '0;
         end
      end else begin
         dly_r[0] <= raw_on_r;
         for (int k = 1; k < DLY_LEN; k++) begin
            dly_r[k] <= dly_r[k-1];
         end
      end
   end

   always_comb begin
      for (int ch = 0; ch < NCH; ch++) begin
         if (delay_en && ch > 0) begin
            stag_on[ch] = dly_r[ch*DELAY_STEP_CYC-1][ch];
         end else begin
            stag_on[ch] = raw_on_r[ch];
         end
      end
   end

   always_ff @(posedge I_CORE_CLK) begin
      if (I_SRST) begin
         O_CHANNEL_OUTPUT <= '0;
      end else if (od_s) begin
         O_CHANNEL_OUTPUT <= '0;
      end else begin
         O_CHANNEL_OUTPUT <= stag_on;
      end
   end

   // led fault detection, sampled a fixed time after switch on
   logic [4:0] on_cnt_r [NCH];

   always_ff @(posedge I_CORE_CLK) begin
      if (I_SRST) begin
         for (int ch = 0; ch < NCH; ch++) begin
            on_cnt_r[ch] <= '0;
         end
         open_flag_r <= '0;
         short_flag_r <= '0;
      end else begin
         for (int ch = 0; ch < NCH; ch++) begin
            if (!O_CHANNEL_OUTPUT[ch]) begin
               on_cnt_r[ch] <= '0;
            end else if (on_cnt_r[ch] != 5'(OPEN_SAMPLE_CYC)) begin
               on_cnt_r[ch] <= on_cnt_r[ch] + 5'h01;
               if (on_cnt_r[ch] == 5'(OPEN_SAMPLE_CYC - 1) && detect_en) begin
                  open_flag_r[ch] <= open_cmp_s[ch];
                  short_flag_r[ch] <= short_cmp_s[ch];
               end
            end
         end
      end
   end

   // open-drain error line
   logic err_assert;
   always_comb begin
      if (od_s) begin
         err_assert = mode_s ? twf_s : tef_s;
      end else begin
         err_assert = tef_s | (|open_flag_r);
      end
   end

   always_ff @(posedge I_CORE_CLK) begin
      if (I_SRST) begin
         O_ERROR_LINE_N_OE <= 1'b0;
      end else begin
         O_ERROR_LINE_N_OE <= err_assert;
      end
   end

   always_ff @(posedge I_CORE_CLK) begin
      O_ERROR_LINE_N_O <= 1'b0;
   end

   // apb slave, one wait state per access
   logic apb_acc, apb_done;
   logic [31:0] rd_val;
   logic rd_err;
   assign apb_acc = I_PSEL & I_PENABLE;
   assign apb_done = apb_acc & O_PREADY;

   always_comb begin
      rd_val = '0;
      rd_err = 1'b0;
      if (I_PADDR == OFS_CTRL) begin
         rd_val[1:0] = ctrl_r;
      end else if (I_PADDR == OFS_STATUS) begin
         rd_val[3:0] = {mode_s, od_s, twf_s, tef_s};
      end else if (I_PADDR == OFS_FLAGS) begin
         rd_val = {short_flag_r, open_flag_r};
      end else if (I_PADDR == OFS_COUNT) begin
         rd_val[CNT_W-1:0] = cnt_r;
      end else begin
         rd_err = 1'b1;
      end
   end

   always_ff @(posedge I_CORE_CLK) begin
      if (I_SRST) begin
         O_PREADY <= 1'b0;
         O_PRDATA <= '0;
         O_PSLVERR <= 1'b0;
      end else if (apb_acc && !O_PREADY) begin
         O_PREADY <= 1'b1;
         O_PRDATA <= I_PWRITE ? 32'h0000_0000 : rd_val;
         O_PSLVERR <= rd_err;
      end else begin
         O_PREADY <= 1'b0;
         O_PRDATA <= '0;
         O_PSLVERR <= 1'b0;
      end
   end

   always_ff @(posedge I_CORE_CLK) begin
      if (I_SRST) begin
         ctrl_r <= CTRL_RST;
      end else if (apb_done && I_PWRITE && I_PADDR == OFS_CTRL) begin
         ctrl_r <= I_PWDATA[1:0];
      end
   end

   // checks
   default clocking cb @(posedge I_CORE_CLK); endclocking
   default disable iff (I_SRST);

   a_od_channels_off: assert property (od_s |=> O_CHANNEL_OUTPUT == '0)
      else $error("channel on while output disable high");
   a_od_count_clear: assert property (od_s |=> cnt_r == '0)
      else $error("pwm counter not cleared by output disable");
   a_shift_msb_first: assert property ((sclk_rise && !ld_rise) |=> sr_r[0] == $past(sin_s))
      else $error("serial input bit not shifted in");
   a_serial_out_tap: assert property (1'b1 |=> O_SERIAL_OUT ==
      ($past(mode_s) ? $past(sr_r[SR_DC_LEN-1]) : $past(sr_r[SR_GS_LEN-1])))
      else $error("serial output from wrong register length");
   a_err_thermal: assert property ((tef_s && !(od_s && mode_s)) |=> O_ERROR_LINE_N_OE)
      else $error("thermal error not driven on error line");
   a_err_masked: assert property ((od_s && !tef_s && !twf_s) |=> !O_ERROR_LINE_N_OE)
      else $error("open flag reached error line while disabled");
   a_gs_latch: assert property ((ld_rise && !mode_s) |=> gs_r[1] == $past(sr_r[23:12]))
      else $error("greyscale value not latched");
   a_dc_latch: assert property ((ld_rise && mode_s) |=> dc_r[1] == $past(sr_r[11:6]))
      else $error("dot correction value not latched");
   a_sid_thermal: assert property ((ld_rise && !mode_s) |=>
      sr_r[SID_TEF] == $past(tef_s) && sr_r[SID_OPEN_LSB +: NCH] == $past(open_flag_r))
      else $error("status packet not loaded after latch");
   // helper: cycles channel 2 has stood on, for the fault sample check
   logic [4:0] chk_on2_r;

   always_ff @(posedge I_CORE_CLK) begin
      if (I_SRST) begin
         chk_on2_r <= '0;
      end else if (!O_CHANNEL_OUTPUT[2]) begin
         chk_on2_r <= '0;
      end else if (chk_on2_r != 5'h1f) begin
         chk_on2_r <= chk_on2_r + 5'h01;
      end
   end

   a_open_sample: assert property ((detect_en && O_CHANNEL_OUTPUT[2] &&
      chk_on2_r == 5'(OPEN_SAMPLE_CYC - 1)) |=> open_flag_r[2] == $past(open_cmp_s[2]))
      else $error("open flag not sampled after switch on");

endmodule : ldsc_top

// ---- tb_led_driver_serial_ctrl.sv ----
// testbench of the serial led driver control block
`timescale 1ns/1ps
module tb_led_driver_serial_ctrl;
   import ldsc_pkg::*;
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic mode = 1'b0;
   logic od = 1'b1;
   logic pwm = 1'b0;
   logic thermal_error_flag = 1'b0;
   logic thermal_warning_flag = 1'b0;
   logic [NCH-1:0] open_cmp = '0;
   logic [NCH-1:0] short_cmp = '0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [ADDR_W-1:0] paddr = '0;
   logic [31:0] pwdata = '0;
   logic [31:0] prdata;
   logic pready, pslverr, sclk, sdin, ld, sdout, oe, od_o;
   logic [NCH-1:0] chan;
   logic [191:0] gsp;
   logic [95:0] dcx = 96'h0123_4567_89ab_cdef_fedc_ba98;
   logic [31:0] rd;
   logic er;
   int error_cnt = 0;
   int check_count = 0;
   wire logic err_line_n = oe ? od_o : 1'b1;
   always #25 clk = ~clk;
   ldsc_top uut (.I_CORE_CLK(clk), .I_SRST(srst), .I_SHIFT_CLK(sclk), .I_SERIAL_IN(sdin),
      .I_LOAD_STROBE(ld), .I_MODE(mode), .I_OUTPUT_DISABLE(od), .I_PWM_COUNT_CLOCK(pwm),
      .I_THERMAL_ERROR(thermal_error_flag), .I_THERMAL_WARNING(thermal_warning_flag), .I_OPEN_CMP(open_cmp),
      .I_SHORT_CMP(short_cmp), .I_PSEL(psel), .I_PENABLE(penable), .I_PWRITE(pwrite),
      .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready),
      .O_PSLVERR(pslverr), .O_SERIAL_OUT(sdout), .O_CHANNEL_OUTPUT(chan),
      .O_ERROR_LINE_N_O(od_o), .O_ERROR_LINE_N_OE(oe));
   ldsc_host_model host (.i_clk(clk), .i_serial_out(sdout), .o_shift_clk(sclk),
      .o_serial_in(sdin), .o_load_strobe(ld));
   task automatic chk(input logic c, input string m);
      check_count++;
      if (c !== 1'b1) begin
         error_cnt++;
         $display("Error %0t %s", $time, m);
      end
   endtask : chk
   task automatic settle(input int n);
      repeat (n) @(posedge clk);
   endtask : settle
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge clk) penable <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      chk(n < 50, "no apb answer");
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic pulse();
      @(posedge clk) pwm <= 1'b1;
      settle(4);
      pwm <= 1'b0;
      settle(8);
   endtask : pulse
   task automatic t_reset();
      chk(sdout === 1'b0 && chan === '0 && oe === 1'b0, "outputs after reset");
      apb(1'b0, OFS_CTRL, 32'h0);
      chk(rd === {30'h0, CTRL_RST} && er === 1'b0, "ctrl reset value");
      apb(1'b1, OFS_CTRL, 32'h0);
      apb(1'b0, OFS_CTRL, 32'h0);
      chk(rd === 32'h0, "ctrl write");
      apb(1'b1, OFS_CTRL, 32'h1);
      apb(1'b0, 12'h010, 32'h0);
      chk(er === 1'b1 && rd === 32'h0, "unmapped read");
      $display("test reset done");
   endtask : t_reset
   task automatic t_chain();
      host.send(gsp, SR_GS_LEN);
      chk(host.cap_r === '0, "register clear after reset");
      host.send(gsp, SR_GS_LEN);
      chk(host.cap_r === gsp, "192 bit chain");
      host.load();
      host.send(gsp, SR_GS_LEN);
      chk(host.cap_r[167:72] === {NCH{DC_RST}}, "dot correction reset");
      host.load();
      $display("test chain done");
   endtask : t_chain
   task automatic t_dc();
      @(posedge clk) mode <= 1'b1;
      settle(8);
      host.send({96'h0, dcx}, SR_DC_LEN);
      host.send({96'h0, dcx}, SR_DC_LEN);
      chk(host.cap_r[95:0] === dcx, "96 bit chain");
      host.load();
      @(posedge clk) mode <= 1'b0;
      settle(8);
      $display("test dot correction done");
   endtask : t_dc
   task automatic t_pwm();
      @(posedge clk) open_cmp <= 16'h00a4;
      short_cmp <= 16'h5a00;
      od <= 1'b0;
      settle(8);
      pulse();
      chk(chan === 16'hfffe, "first pulse");
      settle(30);
      chk(err_line_n === 1'b0, "open flag on error line");
      apb(1'b0, OFS_FLAGS, 32'h0);
      chk(rd === 32'h5a0000a4, "fault flags");
      pulse();
      pulse();
      chk(chan === 16'hfff8, "compare switches off");
      apb(1'b0, OFS_COUNT, 32'h0);
      chk(rd === 32'h3, "counter");
      @(posedge clk) od <= 1'b1;
      settle(8);
      chk(chan === '0, "disable forces off");
      chk(err_line_n === 1'b1, "open masked");
      apb(1'b0, OFS_COUNT, 32'h0);
      chk(rd === 32'h0, "counter cleared");
      @(posedge clk) thermal_error_flag <= 1'b1;
      settle(8);
      chk(err_line_n === 1'b0, "thermal error");
      @(posedge clk) mode <= 1'b1;
      settle(8);
      chk(err_line_n === 1'b1, "mode 1 ignores error");
      @(posedge clk) thermal_warning_flag <= 1'b1;
      settle(8);
      chk(err_line_n === 1'b0, "thermal warning");
      apb(1'b0, OFS_STATUS, 32'h0);
      chk(rd === 32'hf && er === 1'b0, "status pins");
      @(posedge clk) mode <= 1'b0;
      settle(8);
      $display("test pwm done");
   endtask : t_pwm
   task automatic t_stagger();
      int n;
      int k;
      n = 0;
      k = 0;
      apb(1'b1, OFS_CTRL, 32'h3);
      @(posedge clk) od <= 1'b0;
      settle(8);
      @(posedge clk) pwm <= 1'b1;
      while (chan[1] !== 1'b1 && n < 40) begin
         @(posedge clk);
         n++;
      end
      while (chan[15] !== 1'b1 && k < 40) begin
         @(posedge clk);
         k++;
      end
      chk(n < 40 && k == 14, "stagger span");
      pwm <= 1'b0;
      settle(8);
      @(posedge clk) od <= 1'b1;
      settle(8);
      chk(chan === '0, "stagger off by disable");
      apb(1'b1, OFS_CTRL, 32'h1);
      $display("test stagger done");
   endtask : t_stagger
   task automatic t_status();
      host.send(gsp, SR_GS_LEN);
      host.load();
      host.send(192'h0, SR_GS_LEN);
      chk(host.cap_r[191:176] === 16'h00a4 && host.cap_r[31:16] === 16'h00a4, "open");
      chk(host.cap_r[175:174] === 2'h3, "thermal flags");
      chk(host.cap_r[167:72] === dcx && host.cap_r[15:0] === 16'h5a00, "dc, short");
      $display("test status done");
   endtask : t_status
   task automatic tally_and_finish();
      $display("checks %0d errors %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : tally_and_finish
   initial begin
      for (int n = 0; n < NCH; n++) begin
         gsp[n*GS_W +: GS_W] = GS_W'(n);
      end
      settle(10);
      srst <= 1'b0;
      settle(4);
      t_reset();
      t_chain();
      t_dc();
      t_pwm();
      t_stagger();
      t_status();
      tally_and_finish();
   end
   initial begin
      settle(30000);
      error_cnt++;
      tally_and_finish();
   end
endmodule : tb_led_driver_serial_ctrl
